// [hw/address_break_pkg.sv]
package address_break_pkg;
   localparam int addr_width = 16;
   localparam logic [15:0] normal_break_vector = 16'hfffc;
   localparam logic [15:0] monitor_break_vector = 16'hfefc;
   localparam logic [7:0] software_interrupt_opcode = 8'h83;
   localparam logic [7:0] return_from_interrupt_opcode = 8'h80;
   localparam logic [7:0] opcode_idle = 8'h00;
   localparam logic [15:0] break_addr_reset = 16'hffff;
   typedef enum logic [1:0] {idle_s, pending_s, active_s} break_state_t;
endpackage

// [hw/address_break_unit.sv]
// Behaviour
// [R1] Assert breakpoint request when CPU address equals the break address.
// [R2] Software writing break active bit starts a break like a match.
// [R3] On break start, substitute the software interrupt opcode for fetch.
// [R4] Break vector is FFFC/FFFD normally, FEFC/FEFD in monitor mode.
// [R5] Return from interrupt in the break handler ends the break state.
// [R6] Watchdog supervisor held disabled while a break is active.
// [R7] Peripheral registers stay accessible by the CPU during a break.
// [R8] Status bits clearable in break only when clear-flag enable is set.
// [R9] Compare full 16 bits; hold request until accepted at boundary.
`timescale 1ns/10ps
`default_nettype none
module address_break_unit
   import address_break_pkg::*;
#(
   parameter int aw = addr_width
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [aw-1:0] cpu_addr_in,
   input wire logic cpu_fetch_in,
   input wire logic [7:0] fetched_opcode_in,
   input wire logic instr_boundary_in,
   input wire logic break_enable_in,
   input wire logic [aw-1:0] break_addr_in,
   input wire logic break_active_bit_in,
   input wire logic break_clear_flag_enable_in,
   input wire logic monitor_mode_in,
   output logic breakpoint_request_out,
   output logic force_opcode_out,
   output logic [7:0] opcode_out,
   output logic load_vector_out,
   output logic [15:0] vector_addr_out,
   output logic break_state_out,
   output logic watchdog_hold_out,
   output logic periph_access_ok_out,
   output logic status_clear_allow_out
);
   logic rst_meta, rst_sync;
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   break_state_t state, next_state;
   logic next_req, next_force, next_load, next_act, next_clear_allow;
   logic [7:0] next_opcode;
   logic [15:0] next_vector;
   logic addr_hit, sw_hit;

   always_comb begin
      addr_hit = break_enable_in && cpu_fetch_in
                 && (cpu_addr_in == break_addr_in); // [R1] [R9]
      sw_hit = break_active_bit_in; // [R2]
      next_state = state;
      next_req = 1'b0;
      next_force = 1'b0;
      next_load = 1'b0;
      next_opcode = opcode_out;
      next_vector = vector_addr_out;
      unique case (state)
         idle_s: begin
            if (addr_hit || sw_hit) begin
               next_state = pending_s;
               next_req = 1'b1;
            end
         end
         pending_s: begin
            next_req = 1'b1; // [R9]
            if (instr_boundary_in) begin
               next_state = active_s;
               next_req = 1'b0;
               next_force = 1'b1; // [R3]
               next_opcode = software_interrupt_opcode; // [R3]
               next_load = 1'b1;
               next_vector = monitor_mode_in ? monitor_break_vector
                                             : normal_break_vector; // [R4]
            end
         end
         active_s: begin
            // Only a fetched return ends it; nested matches are ignored
            if (cpu_fetch_in
                && fetched_opcode_in == return_from_interrupt_opcode)
               next_state = idle_s; // [R5]
         end
         default: next_state = idle_s;
      endcase
      next_act = (next_state == active_s);
      next_clear_allow = !next_act || break_clear_flag_enable_in; // [R8]
   end

   always_ff @(posedge sys_clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= idle_s;
         breakpoint_request_out <= 1'b0;
         force_opcode_out <= 1'b0;
         opcode_out <= opcode_idle;
         load_vector_out <= 1'b0;
         vector_addr_out <= normal_break_vector;
         break_state_out <= 1'b0;
         watchdog_hold_out <= 1'b0;
         periph_access_ok_out <= 1'b1;
         status_clear_allow_out <= 1'b1;
      end else begin
         state <= next_state;
         breakpoint_request_out <= next_req;
         force_opcode_out <= next_force;
         opcode_out <= next_opcode;
         load_vector_out <= next_load;
         vector_addr_out <= next_vector;
         break_state_out <= next_act;
         watchdog_hold_out <= next_act; // [R6]
         periph_access_ok_out <= 1'b1; // [R7]
         status_clear_allow_out <= next_clear_allow; // [R8]
      end
   end

   property p_match_req;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == idle_s && addr_hit) |=> breakpoint_request_out;
   endproperty
   a_match_req: assert property (p_match_req) else $error("no req"); // [R1]

   property p_sw_req;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == idle_s && sw_hit) |=> state == pending_s;
   endproperty
   a_sw_req: assert property (p_sw_req) else $error("sw break lost"); // [R2]

   property p_force;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      $rose(break_state_out) |-> force_opcode_out
         && opcode_out == software_interrupt_opcode;
   endproperty
   a_force: assert property (p_force) else $error("no forced opcode"); // [R3]

   property p_vector;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == pending_s && instr_boundary_in) |=> load_vector_out
         && vector_addr_out == ($past(monitor_mode_in)
            ? monitor_break_vector : normal_break_vector);
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector"); // [R4]

   property p_return;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == active_s && cpu_fetch_in
       && fetched_opcode_in == return_from_interrupt_opcode)
      |=> !break_state_out;
   endproperty
   a_return: assert property (p_return) else $error("return ignored"); // [R5]

   property p_wdog;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      watchdog_hold_out == (state == active_s);
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog run"); // [R6]

   property p_periph;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      break_state_out |-> periph_access_ok_out;
   endproperty
   a_periph: assert property (p_periph) else $error("io blocked"); // [R7]

   property p_protect;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (next_act && !break_clear_flag_enable_in) |=> !status_clear_allow_out;
   endproperty
   a_protect: assert property (p_protect) else $error("unprotected"); // [R8]

   property p_hold;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == pending_s && !instr_boundary_in) |=> breakpoint_request_out;
   endproperty
   a_hold: assert property (p_hold) else $error("req dropped"); // [R9]

   property p_reqlvl;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      breakpoint_request_out == (state == pending_s);
   endproperty
   a_reqlvl: assert property (p_reqlvl) else $error("req level"); // [R9]

   property p_accept;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == pending_s && instr_boundary_in)
      |=> break_state_out && !breakpoint_request_out;
   endproperty
   a_accept: assert property (p_accept) else $error("no entry"); // [R9]

   // Matches during a break are dropped, not queued for later
   property p_refuse;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == active_s && (addr_hit || sw_hit)) |=> !breakpoint_request_out;
   endproperty
   a_refuse: assert property (p_refuse) else $error("nested req"); // [R1]

   property p_pulse;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      force_opcode_out |=> !force_opcode_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long force"); // [R3]

   property p_load;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      load_vector_out == force_opcode_out;
   endproperty
   a_load: assert property (p_load) else $error("load skew"); // [R4]

   property p_stay;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (state == active_s && !cpu_fetch_in) |=> break_state_out;
   endproperty
   a_stay: assert property (p_stay) else $error("break lost"); // [R5]

   property p_allow;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      (next_act && break_clear_flag_enable_in) |=> status_clear_allow_out;
   endproperty
   a_allow: assert property (p_allow) else $error("clear blocked"); // [R8]

   property p_open;
      @(posedge sys_clk_in) disable iff (!rst_sync)
      !break_state_out |-> status_clear_allow_out;
   endproperty
   a_open: assert property (p_open) else $error("idle protect"); // [R8]
endmodule // address_break_unit
`default_nettype wire

// [verification/cpu_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module cpu_partner (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic [1:0] delay_in,
   output logic boundary_out
);
   logic [1:0] cnt = 2'h0;
   initial boundary_out = 1'b0;
   // Stalls up to three cycles before the next instruction boundary
   always @(negedge clk_in) begin
      boundary_out <= req_in && (cnt == delay_in);
      cnt <= (req_in && cnt != delay_in) ? cnt + 2'h1 : 2'h0;
   end
endmodule // cpu_partner
`default_nettype wire

// [verification/tb_address_break_unit.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_address_break_unit;
   import address_break_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] baddr = 16'h0000;
   logic fetch = 1'b0, en = 1'b0, sw = 1'b0, cfe = 1'b0, mmode = 1'b0;
   logic [7:0] op = 8'h00;
   logic [1:0] dly = 2'h0;
   logic bnd, req, frc, load, bst, wd, pok, sca;
   logic [7:0] op_o;
   logic [15:0] vec;
   logic [25:0] exp_q[$];
   int n_mismatch = 0, samples_checked = 0, seed = 29657, i;
   always #4 clk = ~clk;
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Break entry is judged only where the pulse appears
   always @(posedge clk) begin
      #1;
      if (frc === 1'b1)
         chk(exp_q.size() > 0 && {op_o, vec, load, wd} === exp_q.pop_front(),
            "break entry");
   end
   task automatic run(input bit s, m, c, input bit [15:0] x);
      int w;
      @(negedge clk);
      baddr = 16'($random(seed));
      dly = 2'($random(seed));
      {mmode, cfe, sw, en, fetch, op} = {m, c, s, !s, !s, 8'h12};
      addr = baddr ^ x;
      if (x == 16'h0000)
         exp_q.push_back({software_interrupt_opcode,
            m ? monitor_break_vector : normal_break_vector, 2'b11});
      @(negedge clk);
      {fetch, sw} = 2'b00;
      addr = ~baddr;
      chk(req === (x == 16'h0000), "request level");
      if (x != 16'h0000) begin
         repeat (6) @(negedge clk);
         chk(req === 1'b0 && bst === 1'b0, "false match");
         return;
      end
      for (w = 0; w < 10 && bst !== 1'b1; w++) @(negedge clk);
      chk(bst === 1'b1, "no break");
      chk(sca === c && pok && wd, "access in break");
      {fetch, op} = {1'b1, return_from_interrupt_opcode};
      @(negedge clk);
      fetch = 1'b0;
      @(negedge clk);
      chk(!bst && sca && !wd && !frc, "break not ended");
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (i = 0; i < 8; i++) run(i[0], i[1], i[2], 16'h0000);
      for (i = 0; i < 16; i++) run(1'b0, 1'b0, 1'b0, 16'h0001 << i);
      chk(exp_q.size() == 0, "missing entry");
      close_out();
   end
   // Runs take about 1.5 us; allow wide margin
   initial begin
      #20000;
      n_mismatch++;
      close_out();
   end
   cpu_partner u_partner (.clk_in(clk), .req_in(req), .delay_in(dly),
      .boundary_out(bnd));
   address_break_unit DUT (.sys_clk_in(clk), .reset_n_in(rst_n),
      .cpu_addr_in(addr), .cpu_fetch_in(fetch), .fetched_opcode_in(op),
      .instr_boundary_in(bnd), .break_enable_in(en), .break_addr_in(baddr),
      .break_active_bit_in(sw), .break_clear_flag_enable_in(cfe),
      .monitor_mode_in(mmode), .breakpoint_request_out(req),
      .force_opcode_out(frc), .opcode_out(op_o), .load_vector_out(load),
      .vector_addr_out(vec), .break_state_out(bst), .watchdog_hold_out(wd),
      .periph_access_ok_out(pok), .status_clear_allow_out(sca));
endmodule // tb_address_break_unit
`default_nettype wire
